// ---- hdl/ifdb_map.svh ----
// register map, field positions, reset values and fixed vectors of the
// interrupt flag and burst block; assumes a 32-bit word per register
`ifndef IFDB_MAP_SVH
`define IFDB_MAP_SVH
// ------------------------------------------------------------
// register indices; byte address is four times the index
// ------------------------------------------------------------
`define IFDB_IDX_FLAG_CLR 8'h88
`define IFDB_IDX_SW_REQ 8'h89
`define IFDB_IDX_BURST 8'h8A
`define IFDB_IDX_MODE 8'h8C
`define IFDB_IDX_STATUS 8'h90
`define IFDB_IDX_MASK 8'h91
`define IFDB_IDX_FLAGS 8'h92
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define IFDB_MODE_LEVEL_BIT 1
`define IFDB_MODE_FALL_BIT 2
`define IFDB_RST_4 4'h0
`define IFDB_RST_MODE 3'h0
`define IFDB_STAT_RACE_BIT 4
// ------------------------------------------------------------
// start vectors and the fallback vector
// ------------------------------------------------------------
`define IFDB_VEC_EXTERNAL_INTERRUPT_0 6'h0A
`define IFDB_VEC_RX0 6'h12
`define IFDB_VEC_RX1 6'h16
`define IFDB_VEC_DEFAULT 16'h0008
`define IFDB_VEC_BASE 24'hFFFF00
`define IFDB_RESP_OKAY 2'h0
`define IFDB_RESP_SLVERR 2'h2
`endif

// ---- hdl/ifdb_pkg.sv ----
// types shared by the interrupt flag and burst block
// assumes ifdb_map.svh supplies every number
package ifdb_pkg;
  // vector answer handed to the cpu core on a vector read
  typedef struct packed {
    logic valid;
    logic [15:0] vector;
    logic [23:0] addr;
  } ifdb_vec_s;
  // per-channel dma engine feedback
  typedef struct packed {
    logic [3:0] ack;
    logic [3:0] count_zero;
  } ifdb_dma_fb_s;
  typedef enum logic [1:0] {
    IFDB_WR_IDLE = 2'b00,
    IFDB_WR_RESP = 2'b01
  } ifdb_wr_e;
endpackage

// ---- hdl/ifdb_sync.sv ----
// two flip-flop synchroniser for asynchronous pin levels
// assumes the input is a slow level, not a pulse
module ifdb_sync (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  logic q_reg;
  // the first stage feeds only the second
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule // ifdb_sync

// ---- hdl/ifdb_external_interrupt_0_flag.sv ----
// request flip-flop of external interrupt 0 with edge and level modes
// assumes pin is already synchronised to clk_sys
module ifdb_external_interrupt_0_flag (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic pin,
  input wire logic level_mode,
  input wire logic fall_sel,
  input wire logic clr,
  output logic req
);
  logic pin_d_reg;
  logic mode_d_reg;
  logic flag_reg;
  logic flag_next;
  wire active_level = fall_sel ? ~pin : pin;
  wire rise = pin & ~pin_d_reg;
  wire fall = ~pin & pin_d_reg;
  wire edge_hit = ~level_mode & (fall_sel ? fall : rise);
  wire to_level = level_mode & ~mode_d_reg;
  // set wins over a clear write; entering level mode clears
  always_comb begin
    flag_next = flag_reg;
    if (clr || to_level) flag_next = 1'b0;
    if (edge_hit) flag_next = 1'b1;
    if (level_mode && active_level) flag_next = 1'b1; // level set survives a return to edge
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_d_reg <= 1'b0;
      mode_d_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      pin_d_reg <= pin;
      mode_d_reg <= level_mode;
      flag_reg <= flag_next;
    end
  end
  // level mode bypasses the flip-flop, so the request follows the active pin level
  assign req = level_mode ? active_level : flag_reg;

  property p_level_bypass;
    @(posedge clk_sys) disable iff (!nrst)
      level_mode |-> (req == active_level);
  endproperty
  a_level_bypass: assert property (p_level_bypass) else $error("level request not pin level");
  property p_to_level_clr;
    @(posedge clk_sys) disable iff (!nrst)
      (level_mode && !mode_d_reg && !active_level) |=> (flag_reg == 1'b0) || $past(level_mode && active_level);
  endproperty
  a_to_level_clr: assert property (p_to_level_clr) else $error("flag kept on switch to level");
  property p_keep_on_edge;
    @(posedge clk_sys) disable iff (!nrst)
      (flag_reg && !level_mode && $past(level_mode) && !clr) |=> flag_reg;
  endproperty
  a_keep_on_edge: assert property (p_keep_on_edge) else $error("level flag lost in edge mode");
endmodule // ifdb_external_interrupt_0_flag

// ---- hdl/ifdb_top.sv ----
// interrupt request flags and micro-dma software and burst request control
// assumes an axi4-lite master, a dma engine reporting per-channel ack and
// counter-zero pulses, and a cpu core issuing accept and vector-read pulses
`include "ifdb_map.svh"
module ifdb_top (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_interrupt_0,
  input wire logic [1:0] serial_receive_interrupt,
  input wire logic [1:0] rx_buffer_read,
  input wire ifdb_pkg::ifdb_dma_fb_s dma_fb,
  output logic [3:0] dma_req,
  output logic burst_busy,
  output logic cpu_int_req,
  input wire logic cpu_int_accept,
  input wire logic [5:0] cpu_accept_vec,
  input wire logic cpu_vec_read,
  output ifdb_pkg::ifdb_vec_s cpu_vec,
  output logic irq
);
  import ifdb_pkg::*;

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [3:0] sw_req_reg;
  logic [3:0] burst_sel_reg;
  logic [2:0] mode_reg;
  logic [4:0] status_reg;
  logic [4:0] mask_reg;
  logic [1:0] rx_flag_reg;
  logic [3:0] burst_act_reg;
  logic pend_valid_reg;
  logic [5:0] pend_vec_reg;
  ifdb_vec_s cpu_vec_reg;
  ifdb_wr_e wr_state_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [9:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic external_interrupt_0_pin;
  logic external_interrupt_0_req;

  // ------------------------------------------------------------
  // write channel: address and data taken in either order
  // ------------------------------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = (wr_state_reg == IFDB_WR_IDLE) & aw_got_reg & w_got_reg;
  // waddr_reg already holds the word address, so its low byte is the index
  wire [7:0] w_idx = waddr_reg[7:0];
  wire w_lane0 = wstrb_reg[0];
  wire [7:0] w_byte = wdata_reg[7:0];
  wire wr_clr = wr_fire & w_lane0 & (w_idx == `IFDB_IDX_FLAG_CLR);
  wire wr_swreq = wr_fire & w_lane0 & (w_idx == `IFDB_IDX_SW_REQ);
  wire wr_burst = wr_fire & w_lane0 & (w_idx == `IFDB_IDX_BURST);
  wire wr_mode = wr_fire & w_lane0 & (w_idx == `IFDB_IDX_MODE);
  wire wr_mask = wr_fire & w_lane0 & (w_idx == `IFDB_IDX_MASK);
  wire w_mapped = (w_idx == `IFDB_IDX_FLAG_CLR) | (w_idx == `IFDB_IDX_SW_REQ) |
                  (w_idx == `IFDB_IDX_BURST) | (w_idx == `IFDB_IDX_MODE) |
                  (w_idx == `IFDB_IDX_STATUS) | (w_idx == `IFDB_IDX_MASK) |
                  (w_idx == `IFDB_IDX_FLAGS);
  // only the external_interrupt_0 vector matches a flag here; receive vectors are ignored
  wire clr_external_interrupt_0 = wr_clr & (w_byte[5:0] == `IFDB_VEC_EXTERNAL_INTERRUPT_0);
  assign s_axi_awready = ~aw_got_reg & (wr_state_reg == IFDB_WR_IDLE);
  assign s_axi_wready = ~w_got_reg & (wr_state_reg == IFDB_WR_IDLE);
  assign s_axi_bvalid = (wr_state_reg == IFDB_WR_RESP);
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= 10'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bresp_reg <= `IFDB_RESP_OKAY;
      wr_state_reg <= IFDB_WR_IDLE;
    end else begin
      if (aw_take) waddr_reg <= s_axi_awaddr[11:2];
      if (w_take) wdata_reg <= s_axi_wdata;
      if (w_take) wstrb_reg <= s_axi_wstrb;
      case (wr_state_reg)
        IFDB_WR_IDLE: begin
          if (aw_take) aw_got_reg <= 1'b1;
          if (w_take) w_got_reg <= 1'b1;
          if (wr_fire) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bresp_reg <= w_mapped ? `IFDB_RESP_OKAY : `IFDB_RESP_SLVERR;
            wr_state_reg <= IFDB_WR_RESP;
          end
        end
        IFDB_WR_RESP: begin
          if (s_axi_bready) wr_state_reg <= IFDB_WR_IDLE;
        end
        default: wr_state_reg <= IFDB_WR_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read channel: one read at a time, data from a register
  // ------------------------------------------------------------
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [7:0] r_idx = s_axi_araddr[11:4] == 8'h00 ? 8'h00 : s_axi_araddr[9:2];
  wire rd_status = ar_take & (r_idx == `IFDB_IDX_STATUS);
  wire [3:0] chan_pend = sw_req_reg | burst_act_reg;
  wire [31:0] r_mux =
    (r_idx == `IFDB_IDX_SW_REQ) ? {28'h0000000, chan_pend} :
    (r_idx == `IFDB_IDX_BURST) ? {28'h0000000, burst_sel_reg} :
    (r_idx == `IFDB_IDX_MODE) ? {29'h00000000, mode_reg} :
    (r_idx == `IFDB_IDX_STATUS) ? {27'h0000000, status_reg} :
    (r_idx == `IFDB_IDX_MASK) ? {27'h0000000, mask_reg} :
    (r_idx == `IFDB_IDX_FLAGS) ? {29'h00000000, rx_flag_reg, external_interrupt_0_req} : 32'h00000000;
  wire r_mapped = (r_idx == `IFDB_IDX_FLAG_CLR) | (r_idx == `IFDB_IDX_SW_REQ) |
                  (r_idx == `IFDB_IDX_BURST) | (r_idx == `IFDB_IDX_MODE) |
                  (r_idx == `IFDB_IDX_STATUS) | (r_idx == `IFDB_IDX_MASK) |
                  (r_idx == `IFDB_IDX_FLAGS);
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `IFDB_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= r_mux;
      rresp_reg <= r_mapped ? `IFDB_RESP_OKAY : `IFDB_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // external interrupt 0 synchroniser and flag
  // ------------------------------------------------------------
  ifdb_sync u_external_interrupt_0_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d(external_interrupt_0),
    .q(external_interrupt_0_pin)
  );
  ifdb_external_interrupt_0_flag u_external_interrupt_0 (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin(external_interrupt_0_pin),
    .level_mode(mode_reg[`IFDB_MODE_LEVEL_BIT]),
    .fall_sel(mode_reg[`IFDB_MODE_FALL_BIT]),
    .clr(clr_external_interrupt_0),
    .req(external_interrupt_0_req)
  );

  // ------------------------------------------------------------
  // config registers and receive flags
  // ------------------------------------------------------------
  // receive flags ignore the flag-clear register entirely
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      burst_sel_reg <= `IFDB_RST_4;
      mode_reg <= `IFDB_RST_MODE;
      mask_reg <= 5'h00;
      rx_flag_reg <= 2'h0;
    end else begin
      if (wr_burst) burst_sel_reg <= w_byte[3:0];
      if (wr_mode) mode_reg <= w_byte[2:0];
      if (wr_mask) mask_reg <= w_byte[4:0];
      rx_flag_reg <= (rx_flag_reg & ~rx_buffer_read) | serial_receive_interrupt;
    end
  end

  // ------------------------------------------------------------
  // per-channel dma software request and burst hold
  // ------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
      wire start = dma_req[ch] & dma_fb.ack[ch];
      // a burst keeps the request up until the counter hits zero
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          sw_req_reg[ch] <= 1'b0;
          burst_act_reg[ch] <= 1'b0;
        end else begin
          if (start || dma_fb.count_zero[ch]) sw_req_reg[ch] <= 1'b0;
          if (wr_swreq && w_byte[ch]) sw_req_reg[ch] <= 1'b1;
          if (dma_fb.count_zero[ch]) burst_act_reg[ch] <= 1'b0;
          else if (start && burst_sel_reg[ch]) burst_act_reg[ch] <= 1'b1;
        end
      end
      assign dma_req[ch] = sw_req_reg[ch] | burst_act_reg[ch];
    end
  endgenerate
  assign burst_busy = |burst_act_reg;

  // ------------------------------------------------------------
  // cpu request, accept and vector read
  // ------------------------------------------------------------
  // requests are held back, not dropped, while any burst runs
  wire any_flag = external_interrupt_0_req | (|rx_flag_reg);
  assign cpu_int_req = any_flag & ~burst_busy;
  wire src_live = (pend_vec_reg == `IFDB_VEC_EXTERNAL_INTERRUPT_0) ? external_interrupt_0_req :
                  (pend_vec_reg == `IFDB_VEC_RX0) ? rx_flag_reg[0] :
                  (pend_vec_reg == `IFDB_VEC_RX1) ? rx_flag_reg[1] : 1'b0;
  wire race = cpu_vec_read & pend_valid_reg & ~src_live;
  wire [15:0] vec_pick = race ? `IFDB_VEC_DEFAULT : {10'h000, pend_vec_reg};
  assign cpu_vec = cpu_vec_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend_valid_reg <= 1'b0;
      pend_vec_reg <= 6'h00;
      cpu_vec_reg <= '0;
    end else begin
      cpu_vec_reg.valid <= cpu_vec_read & pend_valid_reg;
      if (cpu_int_accept) begin
        pend_valid_reg <= 1'b1;
        pend_vec_reg <= cpu_accept_vec;
      end else if (cpu_vec_read) begin
        pend_valid_reg <= 1'b0;
        cpu_vec_reg.vector <= vec_pick;
        cpu_vec_reg.addr <= `IFDB_VEC_BASE | {8'h00, vec_pick};
      end
    end
  end

  // ------------------------------------------------------------
  // event status, read-to-clear with set winning, and mask
  // ------------------------------------------------------------
  wire [4:0] events = {race, dma_fb.count_zero & burst_act_reg};
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) status_reg <= 5'h00;
    else status_reg <= (rd_status ? 5'h00 : status_reg) | events;
  end
  assign irq = |(status_reg & mask_reg);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_burst_start(int c);
    dma_req[c] && dma_fb.ack[c] && burst_sel_reg[c] && !dma_fb.count_zero[c];
  endsequence
  property p_burst_hold;
    @(posedge clk_sys) disable iff (!nrst)
      s_burst_start(1) |=> dma_req[1] && burst_busy;
  endproperty
  a_burst_hold: assert property (p_burst_hold) else $error("burst request dropped early");
  property p_single;
    @(posedge clk_sys) disable iff (!nrst)
      (dma_req[0] && dma_fb.ack[0] && !burst_sel_reg[0] && !burst_act_reg[0] && !wr_swreq)
        |=> !dma_req[0];
  endproperty
  a_single: assert property (p_single) else $error("single transfer kept request");
  property p_defer;
    @(posedge clk_sys) disable iff (!nrst)
      burst_busy |-> !cpu_int_req;
  endproperty
  a_defer: assert property (p_defer) else $error("interrupt passed during burst");
  property p_release;
    @(posedge clk_sys) disable iff (!nrst)
      ($fell(burst_busy) && any_flag) |-> cpu_int_req;
  endproperty
  a_release: assert property (p_release) else $error("held interrupt not released");
  property p_swreq;
    @(posedge clk_sys) disable iff (!nrst)
      (wr_swreq && w_byte[0]) |=> dma_req[0];
  endproperty
  a_swreq: assert property (p_swreq) else $error("software request not raised");
  property p_burst_wr;
    @(posedge clk_sys) disable iff (!nrst)
      wr_burst |=> burst_sel_reg == $past(w_byte[3:0]);
  endproperty
  a_burst_wr: assert property (p_burst_wr) else $error("burst select not stored");
  sequence s_race;
    cpu_vec_read && pend_valid_reg && !src_live && !cpu_int_accept;
  endsequence
  property p_race;
    @(posedge clk_sys) disable iff (!nrst)
      s_race |=> cpu_vec.valid && cpu_vec.vector == `IFDB_VEC_DEFAULT && cpu_vec.addr == 24'hFFFF08;
  endproperty
  a_race: assert property (p_race) else $error("default vector not returned");
  property p_rx_keep;
    @(posedge clk_sys) disable iff (!nrst)
      (rx_flag_reg[0] && !rx_buffer_read[0]) |=> rx_flag_reg[0];
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("receive flag lost without read");
  property p_clr;
    @(posedge clk_sys) disable iff (!nrst)
      (clr_external_interrupt_0 && !mode_reg[`IFDB_MODE_LEVEL_BIT] && !mode_reg[`IFDB_MODE_FALL_BIT] && !external_interrupt_0_pin)
        ##1 (!external_interrupt_0_pin && !mode_reg[`IFDB_MODE_LEVEL_BIT])[*2] |-> !external_interrupt_0_req;
  endproperty
  a_clr: assert property (p_clr) else $error("flag clear write ignored");
endmodule // ifdb_top

// ---- test/ifdb_cpu_model.sv ----
// behavioural cpu core and external_interrupt_0 pin driver facing the flag block
// assumes the bench calls its tasks just after a rising clk_sys edge
module ifdb_cpu_model (
  input wire logic clk_sys,
  input wire ifdb_pkg::ifdb_vec_s cpu_vec,
  output logic cpu_int_accept,
  output logic [5:0] cpu_accept_vec,
  output logic cpu_vec_read,
  output logic external_interrupt_0_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import ifdb_pkg::*;
  initial begin
    cpu_int_accept = 1'b0;
    cpu_accept_vec = 6'h3F;
    cpu_vec_read = 1'b0;
    external_interrupt_0_pin = 1'b0;
  end
  // pin level is held until the bench changes it, so it stays up through
  // the response sequence and any halt release
  task automatic set_pin(input logic v);
    @(posedge clk_sys) external_interrupt_0_pin <= v;
  endtask
  // accept pulse; the vector lines are scrambled once released
  // this core never restores a changed mask level from the stack
  task automatic accept(input logic [5:0] v);
    @(posedge clk_sys);
    cpu_int_accept <= 1'b1;
    cpu_accept_vec <= v;
    @(posedge clk_sys);
    cpu_int_accept <= 1'b0;
    cpu_accept_vec <= ~v;
  endtask
  // vector read pulse, answer caught in the cycle it stands
  task automatic vec_read(output ifdb_vec_s r);
    r = '0;
    @(posedge clk_sys) cpu_vec_read <= 1'b1;
    @(posedge clk_sys) cpu_vec_read <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (cpu_vec.valid === 1'b1) begin
        r = cpu_vec;
        break;
      end
      @(posedge clk_sys);
    end
  endtask
endmodule // ifdb_cpu_model

// ---- test/tb.sv ----
// self-checking bench of the flag and burst block
// assumes ifdb_top with an axi4-lite slave and the cpu model beside it
`include "ifdb_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ifdb_pkg::*;
  localparam logic [11:0] A_FC = 12'h220, A_SW = 12'h224, A_BU = 12'h228, A_MO = 12'h230;
  localparam logic [11:0] A_ST = 12'h240, A_MK = 12'h244, A_FL = 12'h248;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} ifdb_row_s;
  ifdb_row_s rows [4] = '{'{A_BU, 32'h5, 32'h5, 2'h0}, '{A_BU, 32'hA, 32'hA, 2'h0},
    '{A_FC, 32'h0, 32'h0, 2'h0}, '{12'h3FC, 32'h0, 32'h0, 2'h2}};
  logic clk_sys = 1'b0, nrst = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, dma_req;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [1:0] serial_receive_interrupt = '0, rx_buffer_read = '0;
  ifdb_dma_fb_s dma_fb = '0;
  logic burst_busy, cpu_int_req, cpu_int_accept, cpu_vec_read, irq, external_interrupt_0;
  logic [5:0] cpu_accept_vec;
  ifdb_vec_s cpu_vec, v;
  logic [31:0] d;
  int miscompares = 0, num_checks = 0;
  always #4 clk_sys = ~clk_sys;
  ifdb_top uut (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_interrupt_0,
    .serial_receive_interrupt, .rx_buffer_read, .dma_fb, .dma_req, .burst_busy, .cpu_int_req,
    .cpu_int_accept, .cpu_accept_vec, .cpu_vec_read, .cpu_vec, .irq);
  ifdb_cpu_model cpu (.clk_sys, .cpu_vec, .cpu_int_accept, .cpu_accept_vec, .cpu_vec_read,
    .external_interrupt_0_pin(external_interrupt_0));
  // -----------------------------------------------------------
  // bus, stimulus and compare helpers
  // -----------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  // address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] dd, output logic [1:0] rs);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= dd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] dd, output logic [1:0] rs);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    dd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // one-cycle dma engine feedback pulse, outputs looked at once it lands
  task automatic fb(input logic [3:0] ack, input logic [3:0] cz);
    @(posedge clk_sys) dma_fb <= '{ack: ack, count_zero: cz};
    @(posedge clk_sys) dma_fb <= '0;
    #1;
  endtask
  // pin change plus time for the two-flop synchroniser and the flag
  task automatic pin(input logic p);
    cpu.set_pin(p);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(A_SW, d, r); chk("sw_req", 32'h0, d);
    rd(A_BU, d, r); chk("burst", 32'h0, d);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, r); chk("bresp", 32'(rows[i].r), 32'(r));
      rd(rows[i].a, d, r); chk("rresp", 32'(rows[i].r), 32'(r));
      if (rows[i].r == `IFDB_RESP_OKAY) chk("rdata", rows[i].e, d);
    end
    // single transfer drops right after its ack
    wr(A_BU, 32'h0, r); wr(A_SW, 32'h1, r); #1;
    chk("single_req", 32'h1, 32'(dma_req));
    fb(4'h1, 4'h0); chk("single_done", 32'h0, 32'(dma_req));
    // burst on channel 1, a receive event waits behind it
    wr(A_MK, 32'h2, r); wr(A_BU, 32'h2, r); wr(A_SW, 32'h2, r);
    fb(4'h2, 4'h0); chk("burst_req", 32'h2, 32'(dma_req));
    chk("busy", 32'h1, 32'(burst_busy));
    fb(4'h2, 4'h0); chk("burst_hold", 32'h2, 32'(dma_req));
    @(posedge clk_sys) serial_receive_interrupt <= 2'h1;
    @(posedge clk_sys) serial_receive_interrupt <= 2'h0;
    #1 chk("held_int", 32'h0, 32'(cpu_int_req));
    fb(4'h0, 4'h2); chk("burst_end", 32'h0, 32'(dma_req));
    chk("late_int", 32'h1, 32'(cpu_int_req));
    chk("irq_set", 32'h1, 32'(irq));
    rd(A_ST, d, r); chk("status", 32'h2, d);
    #1 chk("irq_clr", 32'h0, 32'(irq));
    // receive flag ignores the flag-clear register
    wr(A_FC, 32'(`IFDB_VEC_RX0), r); rd(A_FL, d, r); chk("rx_kept", 32'h2, d);
    @(posedge clk_sys) rx_buffer_read <= 2'h1;
    @(posedge clk_sys) rx_buffer_read <= 2'h0;
    rd(A_FL, d, r); chk("rx_gone", 32'h0, d);
    // external_interrupt_0 edge flag, mode switches and level pass-through
    pin(1'b1); rd(A_FL, d, r); chk("edge_set", 32'h1, d);
    wr(A_FC, 32'h0A, r); rd(A_FL, d, r); chk("edge_clr", 32'h0, d);
    pin(1'b0); pin(1'b1); pin(1'b0);
    wr(A_MO, 32'h2, r); rd(A_FL, d, r); chk("to_level", 32'h0, d);
    pin(1'b1); rd(A_FL, d, r); chk("level_hi", 32'h1, d);
    pin(1'b0); rd(A_FL, d, r); chk("level_lo", 32'h0, d);
    pin(1'b1); wr(A_MO, 32'h0, r); pin(1'b0);
    rd(A_FL, d, r); chk("to_edge", 32'h1, d);
    // flag cleared here, one spare cycle before reading it back
    wr(A_FC, 32'h0A, r); @(posedge clk_sys);
    rd(A_FL, d, r); chk("seq_clr", 32'h0, d);
    // falling-edge mode: only a high-to-low pin change sets the flag
    wr(A_MO, 32'h4, r); pin(1'b1); rd(A_FL, d, r); chk("fall_rise", 32'h0, d);
    pin(1'b0); rd(A_FL, d, r); chk("fall_set", 32'h1, d);
    wr(A_FC, 32'h0A, r); wr(A_MO, 32'h0, r); rd(A_FL, d, r); chk("fall_clr", 32'h0, d);
    // flag cleared between accept and vector read
    wr(A_MK, 32'h10, r); pin(1'b1); cpu.accept(`IFDB_VEC_EXTERNAL_INTERRUPT_0);
    wr(A_FC, 32'h0A, r); cpu.vec_read(v);
    chk("race_vec", 32'h0008, 32'(v.vector));
    chk("race_addr", 32'hFFFF08, 32'(v.addr));
    #1 chk("race_irq", 32'h1, 32'(irq));
    rd(A_ST, d, r); chk("race_stat", 32'h10, d);
    pin(1'b0); pin(1'b1); cpu.accept(`IFDB_VEC_EXTERNAL_INTERRUPT_0); cpu.vec_read(v);
    chk("good_vec", 32'h000A, 32'(v.vector));
    chk("good_addr", 32'hFFFF0A, 32'(v.addr));
    wr(A_FC, 32'h0A, r);
    // reset in mid-run brings the registers back to zero
    wr(A_BU, 32'hF, r);
    @(posedge clk_sys) nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(A_BU, d, r); chk("rst_burst", 32'h0, d);
    print_verdict();
  end
endmodule // tb
